// *** rtl/uv_map.svh ***
`ifndef UV_MAP_SVH
`define UV_MAP_SVH
`define UV_CMD_WARN_THRESHOLD 8'h43
`define UV_CMD_FAULT_THRESHOLD 8'h44
`define UV_CMD_FAULT_REACTION 8'h45
`define UV_CMD_DELAY_UNIT 8'hd2
`define UV_REACTION_MSB 7
`define UV_REACTION_LSB 6
`define UV_RETRY_MSB 5
`define UV_RETRY_LSB 3
`define UV_DELAY_MSB 2
`define UV_DELAY_LSB 0
`define UV_WARN_RESET 16'h0000
`define UV_FAULT_RESET 16'h0000
`define UV_REACTION_RESET 8'h00
`define UV_DELAY_UNIT_RESET 8'h00
`define UV_RETRY_FOREVER 3'h7
`define UV_CLOCK_PERIOD_NS 25
`define UV_UNIT_BASE_NS 1000
`define UV_UNIT_BASE_CYCLES ((`UV_UNIT_BASE_NS + `UV_CLOCK_PERIOD_NS - 1) / `UV_CLOCK_PERIOD_NS)
`endif

// *** rtl/uv_pkg.sv ***
package uv_pkg;
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [15:0] data;
	} link_request_t;
	typedef struct packed {
		logic done;
		logic ack;
		logic [15:0] data;
	} link_answer_t;
	typedef struct packed {
		logic clear_bit;
		logic clear_faults;
		logic operation_on;
		logic other_fault;
		logic sample_valid;
		logic [15:0] sample;
	} supervisor_in_t;
	typedef struct packed {
		logic output_enable;
		logic uv_warning;
		logic uv_fault;
		logic restart_pulse;
	} supervisor_out_t;
	typedef enum logic [2:0] {
		st_run,
		st_delay,
		st_off_wait,
		st_restart,
		st_hold_off,
		st_latched
	} reaction_state_t;
endpackage

// *** rtl/uv_fault_response.sv ***
`timescale 1ns/1ps
`include "uv_map.svh"
module uv_fault_response #(
	parameter int unsigned UNIT_BASE_CYCLES = `UV_UNIT_BASE_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_enable,
	input wire logic link_clock,
	input wire uv_pkg::link_request_t link_request,
	output uv_pkg::link_answer_t link_answer,
	input wire logic control_pin,
	input wire logic bias_ok_pin,
	input wire uv_pkg::supervisor_in_t supervisor_in,
	output uv_pkg::supervisor_out_t supervisor_out
);
	import uv_pkg::*;

	typedef struct packed {
		logic req_toggle;
		logic busy;
		link_request_t hold;
		logic [2:0] ack_sync;
		link_answer_t answer;
	} link_state_t;

	typedef struct packed {
		logic [15:0] warn_threshold;
		logic [15:0] fault_threshold;
		logic [7:0] reaction;
		logic [7:0] delay_unit;
		logic [15:0] vout;
		reaction_state_t state;
		logic [7:0] timer;
		logic [15:0] prescale;
		logic [2:0] attempts;
		logic [1:0] control_sync;
		logic [1:0] bias_sync;
		logic [2:0] req_sync;
		logic ack_toggle;
		logic answer_ack;
		logic [15:0] answer_data;
		logic on_prev;
		supervisor_out_t out;
	} core_state_t;

	function automatic logic [7:0] delay_units(input logic [2:0] code);
		delay_units = 8'h01 << code;
	endfunction

	function automatic logic [15:0] unit_cycles(input logic [7:0] unit_code);
		logic [17:0] wide;
		wide = 18'(UNIT_BASE_CYCLES) * (18'(unit_code[1:0]) + 18'h00001);
		unit_cycles = wide[15:0];
	endfunction

	// core state is read by the link side for the returning answer
	core_state_t core, next_core;

	// link side: one request in flight, later ones ignored until answered
	link_state_t link, next_link;

	always_comb begin
		next_link = link;
		next_link.answer.done = 1'b0;
		next_link.ack_sync = {link.ack_sync[1:0], core.ack_toggle};
		if (!link.busy && link_request.valid) begin
			next_link.hold = link_request;
			next_link.req_toggle = ~link.req_toggle;
			next_link.busy = 1'b1;
		end
		if (link.busy && (link.ack_sync[2] != link.ack_sync[1])) begin
			next_link.busy = 1'b0;
			next_link.answer.done = 1'b1;
			next_link.answer.ack = core.answer_ack;
			next_link.answer.data = core.answer_data;
		end
	end

	always_ff @(posedge link_clock or negedge rst_n) begin
		if (!rst_n) begin
			link <= '0;
		end else begin
			link <= next_link;
		end
	end

	assign link_answer = link.answer;

	// core side
	logic [1:0] reaction_mode;
	logic [2:0] retry_limit;
	logic [2:0] delay_code;
	logic fault_now;
	logic warn_now;
	logic on_command;
	logic clear_event;
	logic tick;
	logic timer_done;
	logic req_seen;
	logic retry_left;

	always_comb begin
		reaction_mode = core.reaction[`UV_REACTION_MSB:`UV_REACTION_LSB];
		retry_limit = core.reaction[`UV_RETRY_MSB:`UV_RETRY_LSB];
		delay_code = core.reaction[`UV_DELAY_MSB:`UV_DELAY_LSB];
		fault_now = core.vout < core.fault_threshold;
		warn_now = core.vout < core.warn_threshold;
		on_command = core.control_sync[1] & supervisor_in.operation_on;
		// off-then-on, bias loss or an explicit clear drop the latch
		clear_event = supervisor_in.clear_bit | supervisor_in.clear_faults
			| (on_command & ~core.on_prev) | ~core.bias_sync[1];
		tick = core.prescale == 16'h0000;
		timer_done = tick && (core.timer == 8'h01);
		req_seen = core.req_sync[2] != core.req_sync[1];
		retry_left = (retry_limit == `UV_RETRY_FOREVER) || (core.attempts < retry_limit);
	end

	always_comb begin
		next_core = core;
		next_core.out.restart_pulse = 1'b0;
		next_core.control_sync = {core.control_sync[0], control_pin};
		next_core.bias_sync = {core.bias_sync[0], bias_ok_pin};
		next_core.req_sync = {core.req_sync[1:0], link.req_toggle};
		next_core.on_prev = on_command;
		if (supervisor_in.sample_valid) begin
			next_core.vout = supervisor_in.sample;
		end

		// unit prescaler runs freely; only the timer load on a fault in st_run restarts it
		if (tick) begin
			next_core.prescale = unit_cycles(core.delay_unit) - 16'h0001;
			if (core.timer != 8'h00) begin
				next_core.timer = core.timer - 8'h01;
			end
		end else begin
			next_core.prescale = core.prescale - 16'h0001;
		end

		// register access from the link
		if (req_seen) begin
			next_core.ack_toggle = ~core.ack_toggle;
			next_core.answer_ack = 1'b1;
			next_core.answer_data = 16'h0000;
			unique case (link.hold.code)
				`UV_CMD_WARN_THRESHOLD: begin
					if (link.hold.write) next_core.warn_threshold = link.hold.data;
					next_core.answer_data = core.warn_threshold;
				end
				`UV_CMD_FAULT_THRESHOLD: begin
					if (link.hold.write) next_core.fault_threshold = link.hold.data;
					next_core.answer_data = core.fault_threshold;
				end
				`UV_CMD_FAULT_REACTION: begin
					if (link.hold.write) next_core.reaction = link.hold.data[7:0];
					next_core.answer_data = {8'h00, core.reaction};
				end
				`UV_CMD_DELAY_UNIT: begin
					if (link.hold.write) next_core.delay_unit = link.hold.data[7:0];
					next_core.answer_data = {8'h00, core.delay_unit};
				end
				default: begin
					next_core.answer_ack = 1'b0;
				end
			endcase
		end

		// reaction sequencer
		unique case (core.state)
			st_run: begin
				if (fault_now) begin
					unique case (reaction_mode)
						2'b00: next_core.state = st_run;
						2'b01: begin
							next_core.state = st_delay;
							next_core.timer = delay_units(delay_code);
							next_core.prescale = unit_cycles(core.delay_unit) - 16'h0001;
						end
						2'b10: begin
							next_core.attempts = 3'h0;
							next_core.timer = delay_units(delay_code);
							next_core.prescale = unit_cycles(core.delay_unit) - 16'h0001;
							next_core.state = (retry_limit == 3'h0) ? st_latched : st_off_wait;
						end
						2'b11: next_core.state = st_hold_off;
					endcase
				end
			end
			st_delay: begin
				if (timer_done) begin
					next_core.attempts = 3'h0;
					next_core.timer = delay_units(delay_code);
					if (!fault_now) begin
						next_core.state = st_run;
					end else if (retry_limit == 3'h0) begin
						next_core.state = st_latched;
					end else begin
						next_core.state = st_off_wait;
					end
				end
			end
			st_off_wait: begin
				if (timer_done) begin
					// attempts are spaced start to start by two delays, restart plus off wait
					next_core.state = st_restart;
					next_core.attempts = core.attempts + 3'h1;
					next_core.timer = delay_units(delay_code);
					next_core.out.restart_pulse = 1'b1;
				end
			end
			st_restart: begin
				if (timer_done) begin
					if (!fault_now) begin
						next_core.state = st_run;
					end else if (retry_left) begin
						next_core.state = st_off_wait;
						next_core.timer = delay_units(delay_code);
					end else begin
						next_core.state = st_latched;
					end
				end
			end
			st_hold_off: begin
				if (!fault_now) next_core.state = st_run;
			end
			st_latched: begin
				if (clear_event) next_core.state = st_run;
			end
			default: next_core.state = st_latched;
		endcase

		// off command, bias loss and other faults end any retry sequence
		if (!on_command || !core.bias_sync[1]) begin
			next_core.state = st_run;
			next_core.attempts = 3'h0;
		end else if (supervisor_in.other_fault) begin
			next_core.state = st_latched;
		end

		// sticky flags: a new event beats a clear in the same cycle
		if (clear_event) begin
			next_core.out.uv_fault = 1'b0;
			next_core.out.uv_warning = 1'b0;
		end
		if (fault_now) next_core.out.uv_fault = 1'b1;
		if (warn_now) next_core.out.uv_warning = 1'b1;

		next_core.out.output_enable = on_command && core.bias_sync[1]
			&& !supervisor_in.other_fault
			&& (next_core.state inside {st_run, st_delay, st_restart});
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			core <= '0;
			core.warn_threshold <= `UV_WARN_RESET;
			core.fault_threshold <= `UV_FAULT_RESET;
			core.reaction <= `UV_REACTION_RESET;
			core.delay_unit <= `UV_DELAY_UNIT_RESET;
			core.state <= st_run;
		end else if (clock_enable) begin
			core <= next_core;
		end
	end

	assign supervisor_out = core.out;
endmodule // uv_fault_response

// *** dv/uv_fault_response_asserts.sv ***
`timescale 1ns/1ps
module uv_fault_response_asserts (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clock_enable,
	input wire logic link_clock,
	input wire uv_pkg::link_request_t link_request,
	input wire uv_pkg::link_answer_t link_answer,
	input wire logic control_pin,
	input wire logic bias_ok_pin,
	input wire uv_pkg::supervisor_in_t supervisor_in,
	input wire uv_pkg::supervisor_out_t supervisor_out
);
	import uv_pkg::*;
	logic [7:0] rx;
	logic oe;
	logic f;
	assign oe = supervisor_out.output_enable;
	assign f = supervisor_out.uv_fault;
	// snooped copy, valid only because writes land while the fault flag is steady
	always_ff @(posedge link_clock or negedge rst_n) begin
		if (!rst_n) begin
			rx <= 8'h00;
		end else if (link_request.valid && link_request.write && link_request.code == 8'h45) begin
			rx <= link_request.data[7:0];
		end
	end
	sequence s_req;
		link_request.valid;
	endsequence
	sequence s_ans;
		##[3:12] link_answer.done ##1 !link_answer.done;
	endsequence
	chk_link_answer: assert property (@(posedge link_clock) disable iff (!rst_n)
		s_req |-> s_ans) else $error("link answer late or long");
	chk_ignore_runs: assert property (@(posedge clock) disable iff (!rst_n)
		rx[7:6] == 2'h0 && $rose(f) && $past(oe) |-> oe [*4]) else $error("ignore dropped output");
	chk_delay_runs: assert property (@(posedge clock) disable iff (!rst_n)
		rx[7:6] == 2'h1 && $rose(f) && $past(oe) |-> oe [*6]) else $error("delay cut short");
	chk_disable_now: assert property (@(posedge clock) disable iff (!rst_n)
		rx[7:6] == 2'h2 && $rose(f) |-> !oe) else $error("output not disabled at once");
	chk_no_retry: assert property (@(posedge clock) disable iff (!rst_n)
		rx[7:6] == 2'h2 && rx[5:3] == 3'h0 |-> !supervisor_out.restart_pulse)
		else $error("restart with zero retries");
	chk_pulse_single: assert property (@(posedge clock) disable iff (!rst_n)
		supervisor_out.restart_pulse |=> !supervisor_out.restart_pulse) else $error("long pulse");
	chk_off_cmd: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(control_pin) |-> ##[1:4] !oe) else $error("off command ignored");
	chk_bias_loss: assert property (@(posedge clock) disable iff (!rst_n)
		$fell(bias_ok_pin) |-> ##[1:4] !oe ##1 !supervisor_out.restart_pulse)
		else $error("bias loss ignored");
endmodule // uv_fault_response_asserts
bind uv_fault_response uv_fault_response_asserts chk (.clock(clock), .rst_n(rst_n),
	.clock_enable(clock_enable), .link_clock(link_clock), .link_request(link_request),
	.link_answer(link_answer), .control_pin(control_pin), .bias_ok_pin(bias_ok_pin),
	.supervisor_in(supervisor_in), .supervisor_out(supervisor_out));

// *** dv/uv_link_host.sv ***
`timescale 1ns/1ps
module uv_link_host (
	input wire logic link_clock,
	output uv_pkg::link_request_t link_request,
	input wire uv_pkg::link_answer_t link_answer
);
	import uv_pkg::*;
	initial link_request = '0;
	// one command outstanding; idle lines flipped so stale values never match
	task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
		output logic [15:0] q, output logic a, output logic to);
		@(negedge link_clock);
		link_request = '{valid: 1'b1, write: w, code: c, data: d};
		@(negedge link_clock);
		link_request = '{valid: 1'b0, write: ~w, code: ~c, data: ~d};
		to = 1'b1;
		for (int n = 0; n < 20 && to; n++) begin
			@(negedge link_clock);
			to = link_answer.done !== 1'b1;
		end
		q = link_answer.data;
		a = link_answer.ack;
	endtask
endmodule // uv_link_host

// *** dv/uv_fault_response_tb_top.sv ***
`timescale 1ns/1ps
module uv_fault_response_tb_top;
	import uv_pkg::*;
	logic clock = 1'b0;
	logic link_clock = 1'b0;
	logic rst_n = 1'b0;
	logic control_pin = 1'b1;
	logic bias_ok_pin = 1'b1;
	supervisor_in_t si = '{operation_on: 1'b1, default: '0};
	supervisor_out_t so;
	link_request_t lrq;
	link_answer_t lan;
	int fail_count = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'h73513a54;
	logic [15:0] q;
	logic a;
	logic to;
	int c;
	logic [7:0] cfg [6] = '{8'h0a, 8'h4a, 8'h82, 8'hba, 8'hc2, 8'h62};
	initial forever #12.5 clock = ~clock;
	initial begin
		#7;
		forever #15 link_clock = ~link_clock;
	end
	// short unit keeps the retry windows to a few hundred cycles
	uv_fault_response #(.UNIT_BASE_CYCLES(2)) uut (.clock(clock), .rst_n(rst_n),
		.clock_enable(1'b1), .link_clock(link_clock), .link_request(lrq), .link_answer(lan),
		.control_pin(control_pin), .bias_ok_pin(bias_ok_pin), .supervisor_in(si),
		.supervisor_out(so));
	uv_link_host host (.link_clock(link_clock), .link_request(lrq), .link_answer(lan));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic int pulses(input logic [7:0] b);
		return b[7:6] inside {2'h1, 2'h2} ? int'(b[5:3]) : 0;
	endfunction
	task automatic close_out();
		$display("compares %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rw(input logic w, input logic [7:0] cd, input logic [15:0] d);
		host.xfer(w, cd, d, q, a, to);
		if (to) begin
			fail_count++;
			close_out();
		end
	endtask
	task automatic smp(input logic [15:0] v);
		@(negedge clock);
		si.sample = v;
		si.sample_valid = 1'b1;
		@(negedge clock);
		si.sample_valid = 1'b0;
	endtask
	task automatic clr(input logic b);
		smp(16'h9000);
		si.clear_bit = b;
		si.clear_faults = ~b;
		@(negedge clock);
		si.clear_bit = 1'b0;
		si.clear_faults = 1'b0;
		repeat (3) @(negedge clock);
	endtask
	initial begin
		repeat (5) @(negedge clock);
		rst_n = 1'b1;
		repeat (4) @(negedge clock);
		for (int n = 0; n < 4; n++) begin
			rw(1'b0, n == 3 ? 8'hd2 : 8'h43 + 8'(n), 16'h0000);
			chk({q[15:1], q[0] | ~a}, 16'h0000);
		end
		for (int n = 0; n < 3; n++) begin
			seed = xs(seed);
			rw(1'b1, 8'h43 + 8'(n), seed[15:0]);
			rw(1'b0, 8'h43 + 8'(n), 16'h0000);
			chk(q, n == 2 ? {8'h00, seed[7:0]} : seed[15:0]);
		end
		rw(1'b1, 8'h99, 16'hffff);
		chk(q | 16'(a), 16'h0000);
		cfg[5] = {2'h1, seed[21:19], 3'h2};
		rw(1'b1, 8'h43, 16'h8000);
		rw(1'b1, 8'h44, 16'h4000);
		// off command ends whatever retry run the random setup left behind
		control_pin = 1'b0;
		repeat (4) @(negedge clock);
		control_pin = 1'b1;
		clr(1'b0);
		foreach (cfg[i]) begin
			rw(1'b1, 8'h45, {8'h00, cfg[i]});
			smp(16'h1000);
			repeat (2) @(negedge clock);
			chk(16'(so.output_enable), 16'(cfg[i][7:6] < 2'h2));
			chk(16'(so.uv_warning), 16'h0001);
			c = 0;
			repeat (300) begin
				@(negedge clock);
				c += int'(so.restart_pulse === 1'b1);
			end
			if (cfg[i][5:3] == 3'h7) c = c > 8 ? 7 : 0;
			chk(16'(c), 16'(pulses(cfg[i])));
			smp(16'h9000);
			repeat (2) @(negedge clock);
			if (cfg[i][5:3] != 3'h7) chk(16'(so.output_enable), 16'(cfg[i][7:6] inside {2'h0, 2'h3}));
			clr(i[0]);
			// endless retry leaves the off wait only at its next restart
			if (cfg[i][5:3] == 3'h7) repeat (20) @(negedge clock);
			chk(16'({so.output_enable, so.uv_fault, so.uv_warning}), 16'h0004);
		end
		rw(1'b1, 8'h45, 16'h0082);
		for (int n = 0; n < 3; n++) begin
			smp(16'h1000);
			@(negedge clock);
			{control_pin, bias_ok_pin, si.operation_on} = n == 0 ? 3'b011 : n == 1 ? 3'b101 : 3'b110;
			repeat (4) @(negedge clock);
			chk(16'(so.output_enable), 16'h0000);
			smp(16'h9000);
			{control_pin, bias_ok_pin, si.operation_on} = 3'b111;
			repeat (6) @(negedge clock);
			chk(16'({so.output_enable, so.uv_fault}), 16'h0002);
		end
		close_out();
	end
endmodule // uv_fault_response_tb_top
